//--- core/sysctl_pkg.sv
// Constants, register map and types for the capability and reset control block.
package sysctl_pkg;

  // ---------------------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] OFS_CAP_ZERO     = 12'h008;
  localparam logic [11:0] OFS_CAP_ONE      = 12'h010;
  localparam logic [11:0] OFS_CAP_TWO      = 12'h014;
  localparam logic [11:0] OFS_CAP_THREE    = 12'h018;
  localparam logic [11:0] OFS_CAP_FOUR     = 12'h01C;
  localparam logic [11:0] OFS_BOR_CTRL     = 12'h030;
  localparam logic [11:0] OFS_REG_CTRL     = 12'h034;
  localparam logic [11:0] OFS_SRST_ZERO    = 12'h040;
  localparam logic [11:0] OFS_SRST_ONE     = 12'h044;
  localparam logic [11:0] OFS_SRST_TWO     = 12'h048;
  localparam logic [11:0] OFS_RAW_STATUS   = 12'h050;
  localparam logic [11:0] OFS_EVENT_MASK   = 12'h054;
  localparam logic [11:0] OFS_MASKED_CLR   = 12'h058;

  // ---------------------------------------------------------------------------
  // Capability values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] CAP_ZERO_VAL     = 32'h00070003;
  localparam logic [31:0] CAP_ONE_VAL      = 32'h0000901F;
  localparam logic [31:0] CAP_TWO_VAL      = 32'h01031011;
  localparam logic [31:0] CAP_THREE_VAL    = 32'h830001C0;
  localparam logic [31:0] CAP_FOUR_VAL     = 32'h00000007;
  localparam logic [31:0] CAP_ONE_UNITS    = 32'h000000FF;
  localparam logic [31:0] GATE0_CAP_BITS   = 32'h0000000F;

  // ---------------------------------------------------------------------------
  // Brown-out and regulator control fields
  // ---------------------------------------------------------------------------
  localparam logic [31:0] BOR_CTRL_RESET   = 32'h00007FFD;
  localparam logic [31:0] BOR_CTRL_WMASK   = 32'h0000FFFF;
  localparam int          BOR_WAIT_BIT     = 0;
  localparam int          BOR_SELECT_BIT   = 1;
  localparam int          BOR_DELAY_LSB    = 2;
  localparam int          BOR_DELAY_MSB    = 15;
  localparam int          BOR_DELAY_W      = 14;
  localparam int          REGULATOR_ADJUST_CODE_W           = 6;
  localparam logic [5:0]  REGULATOR_ADJUST_CODE_RESET       = 6'h00;
  localparam logic [5:0]  REGULATOR_ADJUST_CODE_LOW_MAX     = 6'h05;
  localparam logic [5:0]  REGULATOR_ADJUST_CODE_HIGH_MIN    = 6'h1B;
  localparam logic [5:0]  REGULATOR_ADJUST_CODE_HIGH_MAX    = 6'h1F;

  // ---------------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------------
  localparam int          EVT_W            = 7;
  localparam int          EVT_BOR          = 1;
  localparam int          EVT_PLL_LOCK     = 6;
  localparam logic [6:0]  EVT_ZERO         = 7'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 5;
  localparam int          IOSC_PERIOD_NS   = 67;
  localparam int          IOSC_TICK_CYC    = (IOSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TICK_W           = 16;

  typedef enum logic [0:0] {BO_IDLE, BO_WAIT} bo_state_t;

endpackage : sysctl_pkg

//--- core/system_capability_reset_ctrl.sv
// Capability registers, brown-out and regulator control, soft resets, event status.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Capability one bits 15:12 read fixed minimum clock divisor value 0x09.
// - Capability one bits 4..0 read one: PLL, watchdog, trace, serial debug, JTAG.
// - Clock gating control 0 bits pass only where capability bits 3:0 allow.
// - Capability two reports comparator, timers, I2C, serial unit, first UART.
// - Reserved bits read zero; software keeps them unchanged on writes.
// - Brown-out select bit set gives reset, clear gives interrupt event.
// - Regulator code selects output target; reserved codes are refused.
// - Soft reset writes land only where the unit is reported present.
// - Soft reset one holds controls for comparator, timers, I2C, serial, UART.
// - Soft reset two holds controls for ports A, B and C.
// - Raw event status is read-only, set by hardware, bits 6..0.
// - Raw bit 6 sets when the PLL ready timer expires.
// - Interrupt rises only for raw bits whose mask bit is set.
// - Writing one to masked status clears that flag and the raw bit.
module system_capability_reset_ctrl #(
  parameter int unsigned BOR_TICK_CYCLES = sysctl_pkg::IOSC_TICK_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        brownout_detect_i,
  input  wire logic        pll_fault_i,
  input  wire logic        ldo_unreg_i,
  input  wire logic        main_osc_fault_i,
  input  wire logic        int_osc_fault_i,
  input  wire logic        current_limit_i,
  input  wire logic        pll_ready_i,
  input  wire logic [31:0] run_gate_i,
  input  wire logic [31:0] sleep_gate_i,
  input  wire logic [31:0] deep_gate_i,
  output logic      [31:0] run_gate_o,
  output logic      [31:0] sleep_gate_o,
  output logic      [31:0] deep_gate_o,
  output logic      [31:0] soft_reset_zero_o,
  output logic      [31:0] soft_reset_one_o,
  output logic      [31:0] soft_reset_two_o,
  output logic      [5:0]  regulator_adjust_code_o,
  output logic             brownout_reset_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // A masked write keeps every bit that the allow mask does not name.
  // Software reset registers use it so that an absent unit is never reset.
  // The allow masks are constants, so the function folds to plain gates.

  function automatic logic [31:0] masked_write(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [31:0] allow);
    masked_write = (old_val & ~allow) | (new_val & allow);
  endfunction : masked_write

  // The regulator table has two legal runs of codes that wrap around zero.
  // Every code outside both runs is refused, not clamped.

  function automatic logic regulator_adjust_code_ok(input logic [5:0] code);
    regulator_adjust_code_ok = (code <= sysctl_pkg::REGULATOR_ADJUST_CODE_LOW_MAX) ||
              ((code >= sysctl_pkg::REGULATOR_ADJUST_CODE_HIGH_MIN) && (code <= sysctl_pkg::REGULATOR_ADJUST_CODE_HIGH_MAX));
  endfunction : regulator_adjust_code_ok

  // Allow masks come from the capability values, so the two cannot drift apart.
  // Soft reset zero uses only the unit bits; the divisor field is not a unit.

  localparam logic [31:0] SRST_ZERO_ALLOW = sysctl_pkg::CAP_ONE_VAL & sysctl_pkg::CAP_ONE_UNITS;
  localparam logic [31:0] SRST_ONE_ALLOW  = sysctl_pkg::CAP_TWO_VAL;
  localparam logic [31:0] SRST_TWO_ALLOW  = sysctl_pkg::CAP_FOUR_VAL;
  localparam logic [31:0] GATE_ALLOW      = sysctl_pkg::CAP_ONE_VAL & sysctl_pkg::GATE0_CAP_BITS;
  localparam logic [15:0] TICK_LAST       = 16'(BOR_TICK_CYCLES - 1);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  // Two-stage synchroniser for the event pins.
  logic [6:0]                bus_sync1_reg;
  logic [6:0]                bus_sync2_reg;

  // Software-visible control state.
  logic [31:0]               bor_ctrl_reg;
  logic [5:0]                regulator_adjust_code_reg;

  // Software reset controls, one register each for capability one, two and four.
  logic [31:0]               srst_zero_reg;
  logic [31:0]               srst_one_reg;
  logic [31:0]               srst_two_reg;

  // Raw event flags and their interrupt mask.
  logic [6:0]                raw_reg;
  logic [6:0]                raw_next;
  logic [6:0]                mask_reg;

  // Brown-out qualification state.
  logic                      bo_prev_reg;
  sysctl_pkg::bo_state_t     bo_state_reg;
  logic [15:0]               tick_reg;
  logic [13:0]               delay_reg;
  logic                      bo_event;
  logic                      bo_level;
  logic                      bo_rise;
  logic                      bo_confirm;
  logic [13:0]               bor_delay;

  // Write decodes and the read multiplexer.
  logic                      wr_bor;
  logic                      wr_reg;
  logic                      wr_mask;
  logic                      wr_clr;
  logic [6:0]                hw_set;
  logic [31:0]               rd_value;

  // Decodes are plain compares on the full offset; a partial decode would alias
  // reserved offsets onto live registers.

  assign wr_bor    = wr_i && (addr_i == sysctl_pkg::OFS_BOR_CTRL);
  assign wr_reg    = wr_i && (addr_i == sysctl_pkg::OFS_REG_CTRL);
  assign wr_mask   = wr_i && (addr_i == sysctl_pkg::OFS_EVENT_MASK);
  assign wr_clr    = wr_i && (addr_i == sysctl_pkg::OFS_MASKED_CLR);
  assign bor_delay = bor_ctrl_reg[sysctl_pkg::BOR_DELAY_MSB:sysctl_pkg::BOR_DELAY_LSB];
  assign bo_level  = bus_sync2_reg[sysctl_pkg::EVT_BOR];
  assign bo_rise   = bo_level && !bo_prev_reg;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Event pins come from analog monitors and other clock domains.
  // Only the second stage is read; the first may be metastable.
  // The two stages cost two cycles of latency on every event.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_sync1_reg <= sysctl_pkg::EVT_ZERO;
      bus_sync2_reg <= sysctl_pkg::EVT_ZERO;
    end else if (ce_i) begin
      bus_sync1_reg <= {pll_ready_i, current_limit_i, int_osc_fault_i, main_osc_fault_i,
                        ldo_unreg_i, brownout_detect_i, pll_fault_i};
      bus_sync2_reg <= bus_sync1_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Reserved upper bits are dropped on write so that they always read zero.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bor_ctrl_reg <= sysctl_pkg::BOR_CTRL_RESET;
    end else if (ce_i && wr_bor) begin
      bor_ctrl_reg <= wdata_i & sysctl_pkg::BOR_CTRL_WMASK;
    end
  end

  // A reserved code could drive the regulator out of its safe range, so it is dropped.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulator_adjust_code_reg <= sysctl_pkg::REGULATOR_ADJUST_CODE_RESET;
    end else if (ce_i && wr_reg && regulator_adjust_code_ok(wdata_i[5:0])) begin
      regulator_adjust_code_reg <= wdata_i[5:0];
    end
  end

  // Bits of absent units stay zero whatever software writes.
  // Each register decodes its own offset; a write touches at most one of them.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      srst_zero_reg <= '0;
      srst_one_reg  <= '0;
      srst_two_reg  <= '0;
    end else if (ce_i && wr_i) begin
      if (addr_i == sysctl_pkg::OFS_SRST_ZERO) begin
        srst_zero_reg <= masked_write(srst_zero_reg, wdata_i, SRST_ZERO_ALLOW);
      end
      if (addr_i == sysctl_pkg::OFS_SRST_ONE) begin
        srst_one_reg <= masked_write(srst_one_reg, wdata_i, SRST_ONE_ALLOW);
      end
      if (addr_i == sysctl_pkg::OFS_SRST_TWO) begin
        srst_two_reg <= masked_write(srst_two_reg, wdata_i, SRST_TWO_ALLOW);
      end
    end
  end

  // The mask gates the interrupt and the clear; raw flags are recorded regardless.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_reg <= sysctl_pkg::EVT_ZERO;
    end else if (ce_i && wr_mask) begin
      mask_reg <= wdata_i[6:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Brown-out qualification
  // ---------------------------------------------------------------------------
  // The wait is counted in internal-oscillator periods of BOR_TICK_CYCLES each.
  // A new edge during the wait is ignored; only the resample decides.
  // A zero delay behaves as if the wait option were off, since there is
  // nothing to wait for.
  // The counters are reset at entry so that a stale count never shortens a wait.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bo_prev_reg  <= 1'b0;
      bo_state_reg <= sysctl_pkg::BO_IDLE;
      tick_reg     <= '0;
      delay_reg    <= '0;
    end else if (ce_i) begin
      bo_prev_reg <= bo_level;
      case (bo_state_reg)
        sysctl_pkg::BO_IDLE: begin
          if (bo_rise && bor_ctrl_reg[sysctl_pkg::BOR_WAIT_BIT] && (bor_delay != '0)) begin
            bo_state_reg <= sysctl_pkg::BO_WAIT;
            tick_reg     <= '0;
            delay_reg    <= '0;
          end
        end
        sysctl_pkg::BO_WAIT: begin
          if (tick_reg == TICK_LAST) begin
            tick_reg <= '0;
            if (delay_reg == bor_delay - 14'd1) begin
              bo_state_reg <= sysctl_pkg::BO_IDLE;
            end else begin
              delay_reg <= delay_reg + 14'd1;
            end
          end else begin
            tick_reg <= tick_reg + 16'd1;
          end
        end
        default: begin
          bo_state_reg <= sysctl_pkg::BO_IDLE;
        end
      endcase
    end
  end

  // Resample at the last tick: a detector that has dropped is treated as noise.
  assign bo_confirm = (bo_state_reg == sysctl_pkg::BO_WAIT) && (tick_reg == TICK_LAST) &&
                      (delay_reg == bor_delay - 14'd1) && bo_level;
  assign bo_event   = bo_confirm ||
                      (bo_state_reg == sysctl_pkg::BO_IDLE && bo_rise &&
                       !(bor_ctrl_reg[sysctl_pkg::BOR_WAIT_BIT] && (bor_delay != '0)));

  // The reset request is registered so that it is a clean one-cycle pulse.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brownout_reset_o <= 1'b0;
    end else if (ce_i) begin
      brownout_reset_o <= bo_event && bor_ctrl_reg[sysctl_pkg::BOR_SELECT_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Event status
  // ---------------------------------------------------------------------------
  // Flags are level-set: a pin that stays high sets its flag every cycle.
  // The set is applied after the clear, so an event in the cycle of a clear wins.
  // Only masked flags can be cleared, because the clear acts on the masked view.
  // The brown-out flag follows the qualified event, not the raw pin.

  always_comb begin
    hw_set                      = bus_sync2_reg;
    hw_set[sysctl_pkg::EVT_BOR] = bo_event && !bor_ctrl_reg[sysctl_pkg::BOR_SELECT_BIT];
    raw_next                    = raw_reg;
    if (wr_clr) begin
      raw_next = raw_next & ~(wdata_i[6:0] & mask_reg);
    end
    raw_next = raw_next | hw_set;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_reg <= sysctl_pkg::EVT_ZERO;
    end else if (ce_i) begin
      raw_reg <= raw_next;
    end
  end

  // The interrupt is a level built from registers, so it carries no glitches.

  assign irq_o = |(raw_reg & mask_reg);

  // ---------------------------------------------------------------------------
  // Forwarded outputs
  // ---------------------------------------------------------------------------
  // Gating bits without a capability behind them are forwarded as zero.
  // The register adds one cycle of latency but keeps the outputs glitch free.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_gate_o   <= '0;
      sleep_gate_o <= '0;
      deep_gate_o  <= '0;
    end else if (ce_i) begin
      run_gate_o   <= run_gate_i & GATE_ALLOW;
      sleep_gate_o <= sleep_gate_i & GATE_ALLOW;
      deep_gate_o  <= deep_gate_i & GATE_ALLOW;
    end
  end

  assign soft_reset_zero_o       = srst_zero_reg;
  assign soft_reset_one_o        = srst_one_reg;
  assign soft_reset_two_o        = srst_two_reg;
  assign regulator_adjust_code_o = regulator_adjust_code_reg;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Unmapped offsets read zero.
  // The masked view is computed on the fly, so it can never disagree with raw.

  always_comb begin
    rd_value = '0;
    case (addr_i)
      sysctl_pkg::OFS_CAP_ZERO:   rd_value = sysctl_pkg::CAP_ZERO_VAL;
      sysctl_pkg::OFS_CAP_ONE:    rd_value = sysctl_pkg::CAP_ONE_VAL;
      sysctl_pkg::OFS_CAP_TWO:    rd_value = sysctl_pkg::CAP_TWO_VAL;
      sysctl_pkg::OFS_CAP_THREE:  rd_value = sysctl_pkg::CAP_THREE_VAL;
      sysctl_pkg::OFS_CAP_FOUR:   rd_value = sysctl_pkg::CAP_FOUR_VAL;
      sysctl_pkg::OFS_BOR_CTRL:   rd_value = bor_ctrl_reg;
      sysctl_pkg::OFS_REG_CTRL:   rd_value = {26'h0000000, regulator_adjust_code_reg};
      sysctl_pkg::OFS_SRST_ZERO:  rd_value = srst_zero_reg;
      sysctl_pkg::OFS_SRST_ONE:   rd_value = srst_one_reg;
      sysctl_pkg::OFS_SRST_TWO:   rd_value = srst_two_reg;
      sysctl_pkg::OFS_RAW_STATUS: rd_value = {25'h0000000, raw_reg};
      sysctl_pkg::OFS_EVENT_MASK: rd_value = {25'h0000000, mask_reg};
      sysctl_pkg::OFS_MASKED_CLR: rd_value = {25'h0000000, raw_reg & mask_reg};
      default:                    rd_value = '0;
    endcase
  end

  // Read data is registered and held until the next read strobe.
  // A read has no side effect, so a repeated read is always safe.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i && rd_i) begin
      rdata_o <= rd_value;
    end
  end

endmodule : system_capability_reset_ctrl

//--- tb/system_capability_reset_ctrl_props.sv
// Concurrent checks on the ports of the capability and reset control block.
`timescale 1ns/1ps
module system_capability_reset_ctrl_props (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [31:0] run_gate_i,
  input wire logic [31:0] sleep_gate_i,
  input wire logic [31:0] run_gate_o,
  input wire logic [31:0] sleep_gate_o,
  input wire logic [31:0] soft_reset_one_o,
  input wire logic [31:0] soft_reset_two_o,
  input wire logic [5:0]  regulator_adjust_code_o,
  input wire logic        brownout_reset_o,
  input wire logic        irq_o
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic acc;
  assign acc = ce_i && wr_i;

  a_cap_one_fields:
    assert property (ce_i && rd_i && addr_i == sysctl_pkg::OFS_CAP_ONE
      |=> rdata_o[15:12] == 4'h9 && rdata_o[4:0] == 5'h1F) else $error("capability one wrong");
  a_cap_two_read:
    assert property (ce_i && rd_i && addr_i == sysctl_pkg::OFS_CAP_TWO
      |=> rdata_o == 32'h01031011) else $error("capability two wrong");
  a_gate_masked:
    assert property (ce_i |=> run_gate_o == ($past(run_gate_i) & 32'h0000000F)
      && sleep_gate_o == ($past(sleep_gate_i) & 32'h0000000F)) else $error("gate not masked");
  a_srst_one_write:
    assert property (acc && addr_i == sysctl_pkg::OFS_SRST_ONE
      |=> soft_reset_one_o == ($past(wdata_i) & 32'h01031011)) else $error("srst one wrong");
  a_srst_two_write:
    assert property (acc && addr_i == sysctl_pkg::OFS_SRST_TWO
      |=> soft_reset_two_o == ($past(wdata_i) & 32'h00000007)) else $error("srst two wrong");
  a_reg_code_refused:
    assert property (acc && addr_i == sysctl_pkg::OFS_REG_CTRL
      && wdata_i[5:0] inside {[6'h06:6'h1A], [6'h20:6'h3F]}
      |=> $stable(regulator_adjust_code_o)) else $error("reserved code taken");
  a_reg_code_taken:
    assert property (acc && addr_i == sysctl_pkg::OFS_REG_CTRL
      && wdata_i[5:0] inside {[6'h00:6'h05], [6'h1B:6'h1F]}
      |=> {26'h0, regulator_adjust_code_o} == ($past(wdata_i) & 32'h0000003F))
      else $error("legal code not taken");
  a_bor_one_pulse:
    assert property (brownout_reset_o |=> !brownout_reset_o) else $error("reset pulse too long");
  a_mask_off_irq:
    assert property (acc && addr_i == sysctl_pkg::OFS_EVENT_MASK && wdata_i[6:0] == 7'h00
      |=> !irq_o) else $error("irq with mask clear");
  a_raw_upper_zero:
    assert property (ce_i && rd_i && addr_i == sysctl_pkg::OFS_RAW_STATUS
      |=> rdata_o[31:7] == 25'h0) else $error("raw status upper bits set");
endmodule : system_capability_reset_ctrl_props

bind system_capability_reset_ctrl system_capability_reset_ctrl_props u_props (
  .clk_sys_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .run_gate_i,
  .sleep_gate_i, .run_gate_o, .sleep_gate_o, .soft_reset_one_o, .soft_reset_two_o,
  .regulator_adjust_code_o, .brownout_reset_o, .irq_o);

//--- tb/system_capability_reset_ctrl_tb.sv
// Self-checking bench for the capability and reset control block.
`timescale 1ns/1ps
module system_capability_reset_ctrl_tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [11:0] addr_i    = 12'h000;
  logic [31:0] wdata_i   = 32'h00000000;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [6:0]  ev        = 7'h00;
  logic [31:0] gin       = 32'h00000000;
  logic [31:0] rdata_o, run_o, sleep_o, deep_o, srst0, srst1, srst2, d;
  logic [5:0]  code_o;
  logic        bor_rst, irq_o;
  int          n_fail     = 0;
  int          num_checks = 0;

  system_capability_reset_ctrl #(.BOR_TICK_CYCLES(1)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .brownout_detect_i(ev[1]), .pll_fault_i(ev[0]), .ldo_unreg_i(ev[2]),
    .main_osc_fault_i(ev[3]), .int_osc_fault_i(ev[4]), .current_limit_i(ev[5]),
    .pll_ready_i(ev[6]), .run_gate_i(gin), .sleep_gate_i(~gin),
    .deep_gate_i(gin ^ 32'h0000000A), .run_gate_o(run_o), .sleep_gate_o(sleep_o),
    .deep_gate_o(deep_o), .soft_reset_zero_o(srst0), .soft_reset_one_o(srst1),
    .soft_reset_two_o(srst2), .regulator_adjust_code_o(code_o),
    .brownout_reset_o(bor_rst), .irq_o(irq_o));

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic pin(input int i, input logic v);
    @(posedge clk_sys_i);
    ev[i] <= v;
  endtask : pin

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_caps();
    rd(sysctl_pkg::OFS_CAP_ONE, d);
    chk(32'(d[15:12]), 32'h00000009);
    chk(32'(d[4:0]), 32'h0000001F);
    wr(sysctl_pkg::OFS_CAP_TWO, 32'h00000000);
    rd(sysctl_pkg::OFS_CAP_TWO, d);
    chk(d, 32'h01031011);
    rd(sysctl_pkg::OFS_BOR_CTRL, d);
    chk(d, 32'h00007FFD);
    rd(12'h0FC, d);
    chk(d, 32'h00000000);
  endtask : t_caps
  task automatic t_srst();
    logic [11:0] ofs [3];
    logic [31:0] msk [3];
    logic [31:0] outs [3];
    ofs = '{sysctl_pkg::OFS_SRST_ZERO, sysctl_pkg::OFS_SRST_ONE, sysctl_pkg::OFS_SRST_TWO};
    msk = '{32'h0000001F, 32'h01031011, 32'h00000007};
    for (int i = 0; i < 3; i++) begin
      rd(ofs[i], d);
      chk(d, 32'h00000000);
      wr(ofs[i], 32'hFFFFFFFF);
      rd(ofs[i], d);
      outs = '{srst0, srst1, srst2};
      chk(d, msk[i]);
      chk(outs[i], msk[i]);
      wr(ofs[i], 32'h00000000);
    end
  endtask : t_srst
  task automatic t_reg();
    logic [5:0] cur;
    logic [5:0] cv;
    cur = 6'h00;
    for (int c = 0; c < 64; c++) begin
      cv = 6'(c);
      wr(sysctl_pkg::OFS_REG_CTRL, {26'h0, cv});
      if (cv <= 6'h05 || (cv >= 6'h1B && cv <= 6'h1F)) cur = cv;
      rd(sysctl_pkg::OFS_REG_CTRL, d);
      chk(d, {26'h0, cur});
      chk({26'h0, code_o}, {26'h0, cur});
    end
  endtask : t_reg
  task automatic t_gates();
    @(posedge clk_sys_i);
    gin <= 32'hFFFFFFFF;
    cyc(3);
    chk(run_o, 32'h0000000F);
    chk(sleep_o, 32'h00000000);
    chk(deep_o, 32'h00000005);
  endtask : t_gates
  task automatic t_events();
    wr(sysctl_pkg::OFS_BOR_CTRL, 32'h00000000);
    for (int i = 0; i < 7; i++) begin
      pin(i, 1'b1);
      cyc(6);
      pin(i, 1'b0);
      cyc(4);
      wr(sysctl_pkg::OFS_RAW_STATUS, 32'h00000000);
      wr(sysctl_pkg::OFS_MASKED_CLR, 32'h0000007F);
      rd(sysctl_pkg::OFS_RAW_STATUS, d);
      chk(d, 32'h00000001 << i);
      chk({31'h0, irq_o}, 32'h00000000);
      wr(sysctl_pkg::OFS_EVENT_MASK, 32'h00000001 << i);
      rd(sysctl_pkg::OFS_MASKED_CLR, d);
      chk({31'h0, irq_o}, 32'h00000001);
      wr(sysctl_pkg::OFS_MASKED_CLR, 32'h00000001 << i);
      rd(sysctl_pkg::OFS_RAW_STATUS, d);
      chk(d, 32'h00000000);
      chk({31'h0, irq_o}, 32'h00000000);
      wr(sysctl_pkg::OFS_EVENT_MASK, 32'h00000000);
    end
  endtask : t_events
  task automatic t_bor();
    logic seen;
    seen = 1'b0;
    wr(sysctl_pkg::OFS_BOR_CTRL, 32'h00000002);
    pin(1, 1'b1);
    for (int k = 0; k < 20 && !seen; k++) begin
      @(posedge clk_sys_i);
      #1 if (bor_rst === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h00000001);
    if (!seen) summarize();
    pin(1, 1'b0);
    wr(sysctl_pkg::OFS_BOR_CTRL, 32'h00000011);
    rd(sysctl_pkg::OFS_RAW_STATUS, d);
    chk(d, 32'h00000000);
    pin(1, 1'b1);
    pin(1, 1'b0);
    cyc(12);
    rd(sysctl_pkg::OFS_RAW_STATUS, d);
    chk(d, 32'h00000000);
    pin(1, 1'b1);
    cyc(12);
    pin(1, 1'b0);
    rd(sysctl_pkg::OFS_RAW_STATUS, d);
    chk(d, 32'h00000002);
  endtask : t_bor

  initial begin
    cyc(5);
    rst_n_i <= 1'b1;
    t_caps();
    t_srst();
    t_reg();
    t_gates();
    t_events();
    t_bor();
    wr(sysctl_pkg::OFS_SRST_ONE, 32'hFFFFFFFF);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(sysctl_pkg::OFS_SRST_ONE, d);
    chk(d, 32'h00000000);
    summarize();
  end
  // A hung run is cut short and reported as a mismatch.
  initial begin
    #400000;
    n_fail++;
    summarize();
  end
endmodule : system_capability_reset_ctrl_tb
